// ===== rtl/nvt_defs.svh
// Timing and width constants of the store/recall sequencer.
// Assumes a 125 MHz core clock; included by its bare name.
`ifndef NVT_DEFS_SVH
`define NVT_DEFS_SVH

// ****************************************
// Clock and timing figures
// ****************************************
`define NVT_CLK_MHZ           125
`define NVT_RESTORE_MS        20
`define NVT_STORE_MS          8
`define NVT_GRACE_NS          25
`define NVT_RECALL_US         600
`define NVT_CMD_US            500
`define NVT_SLEEP_MS          8
`define NVT_WAKE_MS           20
`define NVT_STANDBY_US        100
`define NVT_CLK_NS            8
// The shortest time, grace, rounds down to whole cycles.
`define NVT_RESTORE_CYC       (`NVT_RESTORE_MS * 1000 * `NVT_CLK_MHZ)
`define NVT_STORE_CYC         (`NVT_STORE_MS * 1000 * `NVT_CLK_MHZ)
`define NVT_GRACE_CYC         (`NVT_GRACE_NS / `NVT_CLK_NS)
`define NVT_RECALL_CYC        (`NVT_RECALL_US * `NVT_CLK_MHZ)
`define NVT_CMD_CYC           (`NVT_CMD_US * `NVT_CLK_MHZ)
`define NVT_SLEEP_CYC         (`NVT_SLEEP_MS * 1000 * `NVT_CLK_MHZ)
`define NVT_WAKE_CYC          (`NVT_WAKE_MS * 1000 * `NVT_CLK_MHZ)
`define NVT_STANDBY_CYC       (`NVT_STANDBY_US * `NVT_CLK_MHZ)
`define NVT_CNT_W             22

`endif

// ===== rtl/nvt_pkg.sv
// Types shared by the store/recall sequencer files.
// Assumes nvt_defs.svh is on the include path.
package nvt_pkg;
	// Operating states of the sequencer.
	typedef enum logic [3:0] {
		NVT_ST_RESTORE = 4'h0,
		NVT_ST_STANDBY = 4'h1,
		NVT_ST_ACTIVE  = 4'h2,
		NVT_ST_CMD     = 4'h3,
		NVT_ST_STORE   = 4'h4,
		NVT_ST_RECALL  = 4'h5,
		NVT_ST_SLEEPG  = 4'h6,
		NVT_ST_SLEEP   = 4'h7,
		NVT_ST_WAKE    = 4'h8,
		NVT_ST_GRACE   = 4'h9,
		NVT_ST_PFSTORE = 4'ha,
		NVT_ST_OFF     = 4'hb
	} nvt_state_t;

	// Commands decoded from the bus side.
	typedef enum logic [2:0] {
		NVT_CMD_NONE   = 3'h0,
		NVT_CMD_STORE  = 3'h1,
		NVT_CMD_RECALL = 3'h2,
		NVT_CMD_SLEEP  = 3'h3
	} nvt_cmd_t;
endpackage : nvt_pkg

// ===== rtl/nvt_seq.sv
// Store/recall/sleep/standby sequencer of a serial nonvolatile SRAM.
// Assumes the bus front end gives same-clock pulses; supply_ok comes from a pin.
`timescale 1ns/100ps

// Summary of operation
// - Power-up restore ends within 20 ms.
// - Skip power-fail store if SRAM unchanged.
// - Writes stay enabled 25 ns after trigger.
// - Ignore accesses during transfers or low supply.
// - Lock bus during store/recall until done.
// - Act on software command within 500 us.
// - Enter sleep within 8 ms.
// - Ready within 20 ms after wake.
// - Standby within 100 us after STOP.
module nvt_seq
	import nvt_pkg::*;
(
	// Clock and reset.
	input  wire logic     clk,
	input  wire logic     rst,
	// Supply monitor pin: high while supply is above trigger.
	input  wire logic     supply_ok,
	// Bus front end events.
	input  wire logic     bus_start,
	input  wire logic     bus_stop,
	input  wire logic     wr_req,
	input  wire logic     rd_req,
	input  wire logic     cmd_valid,
	input  wire nvt_cmd_t cmd_code,
	input  wire logic     wake_req,
	// Gated access strobes and status.
	output logic          wr_en,
	output logic          rd_en,
	output logic          bus_lock,
	output logic          restore_busy,
	output logic          store_busy,
	output logic          store_skipped,
	output logic          sleeping,
	output logic          standby,
	output logic          ready
);
	`include "nvt_defs.svh"

	// ****************************************
	// Supply synchroniser
	// ****************************************
	logic       sup_s1_r;
	logic       sup_s2_r;
	logic       sup_s3_r;
	logic       sup_ok_r;

	// Three stages; the level changes once stages two and three agree.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sup_s1_r <= 1'b0;
			sup_s2_r <= 1'b0;
			sup_s3_r <= 1'b0;
			sup_ok_r <= 1'b0;
		end else begin
			sup_s1_r <= supply_ok;
			sup_s2_r <= sup_s1_r;
			sup_s3_r <= sup_s2_r;
			if (sup_s2_r == sup_s3_r) begin
				sup_ok_r <= sup_s3_r;
			end
		end
	end

	// ****************************************
	// State machine
	// ****************************************
	nvt_state_t state_r;
	nvt_state_t state_nxt;
	nvt_cmd_t   pend_r;
	logic       dirty_r;
	logic       load_nxt;
	logic [`NVT_CNT_W-1:0] count_nxt;
	logic       open_w;
	logic       wr_ok_w;

	nvt_timer_if tif ();

	nvt_timer u_timer (
		.clk (clk),
		.rst (rst),
		.t   (tif.tmr)
	);

	assign tif.load  = load_nxt;
	assign tif.count = count_nxt;

	// Accesses pass only in the idle states with supply good.
	assign open_w  = sup_ok_r && (state_r == NVT_ST_ACTIVE || state_r == NVT_ST_STANDBY);
	// The grace window still lets an in-flight write finish.
	assign wr_ok_w = open_w || (state_r == NVT_ST_GRACE);

	// Sizes an interval for the timer.
	// The loading cycle already counts as one cycle in the new state, so one is
	// taken off; otherwise every interval, grace included, overruns by 8 ns.
	function automatic logic [`NVT_CNT_W-1:0] cyc(input int unsigned n);
		int unsigned m;
		m = (n == 0) ? 0 : n - 1;
		cyc = m[`NVT_CNT_W-1:0];
	endfunction : cyc

	// Next state and timer loads.
	always_comb begin
		state_nxt = state_r;
		load_nxt  = 1'b0;
		count_nxt = '0;
		case (state_r)
			NVT_ST_OFF: begin
				if (sup_ok_r) begin
					state_nxt = NVT_ST_RESTORE;
					load_nxt  = 1'b1;
					count_nxt = cyc(`NVT_RESTORE_CYC);
				end
			end
			NVT_ST_RESTORE, NVT_ST_STORE, NVT_ST_RECALL, NVT_ST_WAKE: begin
				if (tif.done) begin
					state_nxt = NVT_ST_STANDBY;
				end
			end
			NVT_ST_STANDBY, NVT_ST_ACTIVE: begin
				if (cmd_valid && cmd_code != NVT_CMD_NONE) begin
					state_nxt = NVT_ST_CMD;
					load_nxt  = 1'b1;
					count_nxt = cyc(`NVT_CMD_CYC);
				end else if (bus_stop) begin
					state_nxt = NVT_ST_ACTIVE;
					load_nxt  = 1'b1;
					count_nxt = cyc(`NVT_STANDBY_CYC);
				end else if (bus_start || wr_req || rd_req) begin
					state_nxt = NVT_ST_ACTIVE;
				end else if (state_r == NVT_ST_ACTIVE && tif.done) begin
					state_nxt = NVT_ST_STANDBY;
				end
			end
			NVT_ST_CMD: begin
				if (tif.done) begin
					load_nxt = 1'b1;
					case (pend_r)
						NVT_CMD_STORE: begin
							state_nxt = NVT_ST_STORE;
							count_nxt = cyc(`NVT_STORE_CYC);
						end
						NVT_CMD_RECALL: begin
							state_nxt = NVT_ST_RECALL;
							count_nxt = cyc(`NVT_RECALL_CYC);
						end
						NVT_CMD_SLEEP: begin
							state_nxt = NVT_ST_SLEEPG;
							count_nxt = cyc(`NVT_SLEEP_CYC);
						end
						default: begin
							state_nxt = NVT_ST_STANDBY;
							load_nxt  = 1'b0;
						end
					endcase
				end
			end
			NVT_ST_SLEEPG: begin
				if (tif.done) begin
					state_nxt = NVT_ST_SLEEP;
				end
			end
			NVT_ST_SLEEP: begin
				if (wake_req) begin
					state_nxt = NVT_ST_WAKE;
					load_nxt  = 1'b1;
					count_nxt = cyc(`NVT_WAKE_CYC);
				end
			end
			NVT_ST_GRACE: begin
				if (tif.done) begin
					state_nxt = NVT_ST_PFSTORE;
					load_nxt  = 1'b1;
					count_nxt = cyc(`NVT_STORE_CYC);
				end
			end
			NVT_ST_PFSTORE: begin
				if (tif.done) begin
					state_nxt = NVT_ST_OFF;
				end
			end
			default: begin
				state_nxt = NVT_ST_OFF;
			end
		endcase
		// Supply loss overrides all; store only if SRAM was written.
		if (!sup_ok_r && state_r != NVT_ST_OFF && state_r != NVT_ST_GRACE &&
				state_r != NVT_ST_PFSTORE) begin
			load_nxt = dirty_r;
			if (dirty_r) begin
				state_nxt = NVT_ST_GRACE;
				count_nxt = cyc((`NVT_GRACE_CYC < 1) ? 1 : `NVT_GRACE_CYC);
			end else begin
				state_nxt = NVT_ST_OFF;
				count_nxt = '0;
			end
		end
	end

	// State register.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= NVT_ST_OFF;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Latch the accepted command for execution after processing.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pend_r <= NVT_CMD_NONE;
		end else if (open_w && cmd_valid) begin
			pend_r <= cmd_code;
		end
	end

	// Written-since-last-transfer flag; a write in the clearing cycle wins.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dirty_r <= 1'b0;
		end else if (wr_req && wr_ok_w) begin
			dirty_r <= 1'b1;
		end else if (state_r == NVT_ST_RESTORE || state_r == NVT_ST_STORE ||
				state_r == NVT_ST_RECALL || state_r == NVT_ST_PFSTORE) begin
			dirty_r <= 1'b0;
		end
	end

	// Skipped-store indication, held until supply returns.
	// A running power-fail store clears dirty itself, so it must not count as a skip.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			store_skipped <= 1'b0;
		end else if (!sup_ok_r && !dirty_r && state_r != NVT_ST_OFF &&
				state_r != NVT_ST_GRACE && state_r != NVT_ST_PFSTORE) begin
			store_skipped <= 1'b1;
		end else if (state_r == NVT_ST_RESTORE) begin
			store_skipped <= 1'b0;
		end
	end

	// ****************************************
	// Registered outputs
	// ****************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_en        <= 1'b0;
			rd_en        <= 1'b0;
			bus_lock     <= 1'b1;
			restore_busy <= 1'b0;
			store_busy   <= 1'b0;
			sleeping     <= 1'b0;
			standby      <= 1'b0;
			ready        <= 1'b0;
		end else begin
			wr_en        <= wr_req && wr_ok_w;
			rd_en        <= rd_req && open_w;
			bus_lock     <= !open_w;
			restore_busy <= (state_r == NVT_ST_RESTORE);
			store_busy   <= (state_r == NVT_ST_STORE) || (state_r == NVT_ST_PFSTORE);
			sleeping     <= (state_r == NVT_ST_SLEEP);
			standby      <= (state_r == NVT_ST_STANDBY);
			ready        <= open_w;
		end
	end
endmodule : nvt_seq

// ===== rtl/nvt_timer.sv
// Down-counting interval timer for the sequencer.
// Assumes load is a one-cycle pulse on clk.
`timescale 1ns/100ps
module nvt_timer
	import nvt_pkg::*;
(
	// Clock and reset.
	input  wire logic clk,
	input  wire logic rst,
	// Timer port.
	nvt_timer_if.tmr  t
);
	`include "nvt_defs.svh"
	logic [`NVT_CNT_W-1:0] cnt_r;

	// Load the interval, then count to zero and hold done high.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_r <= '0;
		end else if (t.load) begin
			cnt_r <= t.count;
		end else if (cnt_r != '0) begin
			cnt_r <= cnt_r - 1'b1;
		end
	end

	assign t.done = (cnt_r == '0) && !t.load;
endmodule : nvt_timer

// ===== rtl/nvt_timer_if.sv
// Interface between the sequencer and its interval timer.
// Assumes one clock domain.
`timescale 1ns/100ps
interface nvt_timer_if;
	`include "nvt_defs.svh"
	logic                  load;
	logic [`NVT_CNT_W-1:0] count;
	logic                  done;
	modport ctrl (output load, output count, input done);
	modport tmr  (input load, input count, output done);
endinterface : nvt_timer_if

// ===== verification/nvt_master_model.sv
// Bus master model issuing front-end event pulses.
// Assumes the bench calls send from one process at a time.
`timescale 1ns/100ps
module nvt_master_model
	import nvt_pkg::*;
(
	// Clock.
	input  wire logic clk,
	// Front-end events.
	output logic      bus_start,
	output logic      bus_stop,
	output logic      wr_req,
	output logic      rd_req,
	output logic      cmd_valid,
	output nvt_cmd_t  cmd_code
);
	// ****************************************
	// Event driver
	// ****************************************
	// Idle levels from time zero.
	initial begin
		{bus_start, bus_stop, wr_req, rd_req, cmd_valid} = 5'h0;
		cmd_code = NVT_CMD_NONE;
	end
	// Pulses the chosen events for one cycle; the master issues them early, and
	// whatever the device refuses counts as lost.
	task automatic send(input logic [4:0] ev, input nvt_cmd_t c);
		@(negedge clk);
		{bus_start, bus_stop, wr_req, rd_req, cmd_valid} = ev;
		cmd_code = c;
		@(negedge clk);
		{bus_start, bus_stop, wr_req, rd_req, cmd_valid} = 5'h0;
		cmd_code = NVT_CMD_NONE;
	endtask : send
endmodule : nvt_master_model

// ===== verification/nvt_seq_properties.sv
// Port timing checker of the store/recall sequencer.
// Assumes nvt_defs.svh is on the include path and one clock domain.
`timescale 1ns/100ps
module nvt_seq_properties
	import nvt_pkg::*;
(
	// Clock, reset and inputs.
	input wire logic clk,
	input wire logic rst,
	input wire logic supply_ok,
	input wire logic wr_req,
	input wire logic rd_req,
	// Watched outputs.
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic bus_lock,
	input wire logic restore_busy,
	input wire logic store_busy,
	input wire logic store_skipped
);
	`include "nvt_defs.svh"
	// ****************************************
	// Helper counters
	// ****************************************
	logic [23:0] busy_cnt;
	logic [23:0] low_cnt;
	logic        dirty;
	// Busy run length, time below trigger, and writes since the last transfer.
	// A recall has no port of its own, so any lockout is taken as a transfer.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busy_cnt <= 24'h0;
			low_cnt  <= 24'h0;
			dirty    <= 1'b0;
		end else begin
			busy_cnt <= (restore_busy | store_busy) ? busy_cnt + 24'h1 : 24'h0;
			low_cnt  <= supply_ok ? 24'h0 : low_cnt + 24'h1;
			dirty    <= wr_en | (dirty & ~bus_lock);
		end
	end
	// All checks share one clock and reset.
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence s_restore_begin;
		$rose(restore_busy);
	endsequence
	a_wr_after_req: assert property (wr_en |-> $past(wr_req))
		else $error("write strobe without request");
	a_restore_no_rd: assert property (restore_busy && $past(restore_busy) |-> !rd_en)
		else $error("read passed during restore");
	a_store_no_rd: assert property (store_busy && $past(store_busy) |-> !rd_en)
		else $error("read passed during store");
	a_restore_locked: assert property (restore_busy |-> bus_lock)
		else $error("bus open during restore");
	a_restore_bound: assert property (restore_busy |-> busy_cnt <= `NVT_RESTORE_CYC + 8)
		else $error("restore too long");
	a_store_bound: assert property (store_busy |-> busy_cnt <= `NVT_STORE_CYC + `NVT_CMD_CYC + 8)
		else $error("store too long");
	a_grace_bound: assert property (wr_en |-> low_cnt <= 24'hc)
		else $error("write passed after grace");
	a_skip_clean: assert property ($rose(store_skipped) |-> !$past(dirty))
		else $error("store skipped with dirty data");
	a_skip_clear: assert property (s_restore_begin |-> ##[0:3] !store_skipped)
		else $error("skip flag kept over restore");
endmodule : nvt_seq_properties

bind nvt_seq nvt_seq_properties u_prop (.clk, .rst, .supply_ok, .wr_req, .rd_req, .wr_en,
	.rd_en, .bus_lock, .restore_busy, .store_busy, .store_skipped);

// ===== verification/tb.sv
// Self-checking bench of the store/recall sequencer.
// Assumes full-length counts, so only the power-up phases are reached.
`timescale 1ns/100ps
module tb
	import nvt_pkg::*;
;
	logic       clk, rst, supply_ok, wake_req;
	logic       bus_start, bus_stop, wr_req, rd_req, cmd_valid;
	nvt_cmd_t   cmd_code;
	logic       wr_en, rd_en, bus_lock, restore_busy, store_busy;
	logic       store_skipped, sleeping, standby, ready;
	int         errors, n_compared;
	logic [8:0] st;
	// Outputs packed for compact comparison.
	assign st = {wr_en, rd_en, bus_lock, restore_busy, store_busy, store_skipped,
		sleeping, standby, ready};
	nvt_seq uut (.clk, .rst, .supply_ok, .bus_start, .bus_stop, .wr_req, .rd_req,
		.cmd_valid, .cmd_code, .wake_req, .wr_en, .rd_en, .bus_lock, .restore_busy,
		.store_busy, .store_skipped, .sleeping, .standby, .ready);
	nvt_master_model m (.clk, .bus_start, .bus_stop, .wr_req, .rd_req, .cmd_valid,
		.cmd_code);
	// ****************************************
	// Helpers and scenarios
	// ****************************************
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: status %h, expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic stop_test;
		$display("compared %0d, errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : stop_test
	// Supply rise starts a locked restore that drops every event and wake.
	task automatic t_restore;
		supply_ok = 1'b1;
		cyc(10);
		check(st, 9'h060);
		for (int i = 0; i < 5; i++) begin
			m.send(5'h1 << i, NVT_CMD_STORE);
			check(st, 9'h060);
		end
		wake_req = 1'b1;
		cyc(1);
		wake_req = 1'b0;
		cyc(20000);
		check(st, 9'h060);
	endtask : t_restore
	// Clean supply loss skips the store and refuses accesses.
	task automatic t_loss;
		supply_ok = 1'b0;
		cyc(10);
		check(st, 9'h048);
		m.send(5'h6, NVT_CMD_NONE);
		check(st, 9'h048);
	endtask : t_loss
	// A reset in mid-restore returns the idle levels and restarts restore.
	task automatic t_mid_reset;
		rst = 1'b1;
		cyc(2);
		check(st, 9'h040);
		rst = 1'b0;
		cyc(10);
		check(st, 9'h060);
	endtask : t_mid_reset
	// Clock of 8 ns.
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Main sequence.
	initial begin
		errors = 0;
		n_compared = 0;
		rst = 1'b1;
		supply_ok = 1'b0;
		wake_req = 1'b0;
		cyc(5);
		check(st, 9'h040);
		cyc(1);
		rst = 1'b0;
		t_restore;
		t_loss;
		supply_ok = 1'b1;
		cyc(10);
		check(st, 9'h060);
		t_mid_reset;
		stop_test;
	end
	// Watchdog.
	initial begin
		#(100000 * 8);
		errors++;
		stop_test;
	end
endmodule : tb
